// file: sensor_regs_pkg.sv
// Package for the optical motion sensor register bank.
// Assumes the register bank and its serial front end both import it.
package sensor_regs_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_OPERATION_CONTROL = 7'h00;
    localparam logic [6:0] ADDR_PRODUCT_CODE      = 7'h01;
    localparam logic [6:0] ADDR_VERTICAL_MOTION   = 7'h02;
    localparam logic [6:0] ADDR_HORIZONTAL_MOTION = 7'h03;
    localparam logic [6:0] ADDR_FRAME_QUALITY     = 7'h04;
    localparam logic [6:0] ADDR_IDENTIFIER_UPPER  = 7'h14;
    localparam logic [6:0] ADDR_IDENTIFIER_LOWER  = 7'h15;

    // ------------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------------
    localparam int         CTRL_RESET_BIT      = 7;
    localparam int         CTRL_POWER_DOWN_BIT = 6;
    localparam int         CTRL_SLEEP_BIT      = 0;
    localparam logic [7:0] CTRL_WRITABLE_MASK  = 8'h41;
    localparam logic [7:0] CTRL_RESET_VALUE    = 8'h00;
    // Product and identifier codes are arbitrary neutral values.
    localparam logic [2:0]  PRODUCT_CODE_VALUE  = 3'h5;
    localparam logic [11:0] IDENTIFIER_VALUE    = 12'h3a7;
    localparam logic [3:0]  IDENTIFIER_LOW_PAD  = 4'h0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 4000;
    localparam int SLEEP_IDLE_MS   = 1000;
    localparam longint SLEEP_IDLE_CYCLES_L =
        (64'(SLEEP_IDLE_MS) * 64'd1000000000) / 64'(CLK_PERIOD_PS);
    localparam int SLEEP_IDLE_CYCLES = int'(SLEEP_IDLE_CYCLES_L);

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       write;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_request_t;

    typedef struct packed {
        logic signed [7:0] dx;
        logic signed [7:0] dy;
        logic        [7:0] quality;
        logic              moved;
    } motion_sample_t;

    typedef enum logic {
        OP_SLEEP,
        OP_NORMAL
    } op_state_t;

endpackage : sensor_regs_pkg

// file: motion_accum.sv
// Saturating signed accumulator for one motion axis.
// Assumes samples and clear arrive on the system clock.
`timescale 1ns/1ns
module motion_accum #(
    parameter int WIDTH = 8
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    add_en,
    input  wire logic signed [WIDTH-1:0] delta,
    input  wire logic                    clear,
    output logic signed [WIDTH-1:0]      count_reg
);
    localparam logic signed [WIDTH:0] MAXV = (WIDTH+1)'((1 << (WIDTH-1)) - 1);
    localparam logic signed [WIDTH:0] MINV = -MAXV - (WIDTH+1)'(1);

    logic signed [WIDTH:0] sum;
    logic signed [WIDTH:0] base;

    always_comb begin
        base = clear ? '0 : {count_reg[WIDTH-1], count_reg};
        sum  = base + {delta[WIDTH-1], delta};
    end

    // A sample in the clearing cycle starts the next report.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (add_en) begin
            if (sum > MAXV) begin
                count_reg <= MAXV[WIDTH-1:0];
            end else if (sum < MINV) begin
                count_reg <= MINV[WIDTH-1:0];
            end else begin
                count_reg <= sum[WIDTH-1:0];
            end
        end else if (clear) begin
            count_reg <= '0;
        end
    end

endmodule : motion_accum

// file: serial_link_port.sv
// Serial front end on the link clock: address byte, then data byte.
// Assumes sclk runs only during frames; requests cross by toggle and the
// read data word is stable while the host shifts it out.
`timescale 1ns/1ns
module serial_link_port (
    input  wire logic                         sclk,
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         sdio_in,
    output logic                              sdio_out,
    output logic                              sdio_oe,
    input  wire logic [7:0]                   rdata,
    output sensor_regs_pkg::reg_request_t     req_reg,
    output logic                              req_valid
);
    import sensor_regs_pkg::*;

    // The link side has no reset: a frame is always 16 edges from zero.
    logic [3:0]   bitcnt_reg = 4'h0;
    logic [7:0]   shift_reg;
    logic [7:0]   addr_reg;
    reg_request_t hold_reg;
    logic         toggle_reg = 1'b0;
    logic         sync1_reg;
    logic         sync2_reg;
    logic         sync3_reg;
    logic [7:0]   rdata_hold_reg;

    // Link-side shifter; a frame is 16 bits, MSB first.
    always_ff @(posedge sclk) begin
        shift_reg  <= {shift_reg[6:0], sdio_in};
        bitcnt_reg <= bitcnt_reg + 4'd1;
        if (bitcnt_reg == 4'd7) begin
            addr_reg <= {shift_reg[6:0], sdio_in};
            // A read is posted as soon as its address byte is in, so that the
            // word is ready before its first bit goes out.
            if (!shift_reg[6]) begin
                hold_reg   <= '{write: 1'b0, addr: {shift_reg[5:0], sdio_in},
                                wdata: 8'h00};
                toggle_reg <= ~toggle_reg;
            end
        end
        if (bitcnt_reg == 4'd15 && addr_reg[7]) begin
            hold_reg   <= '{write: addr_reg[7], addr: addr_reg[6:0],
                            wdata: {shift_reg[6:0], sdio_in}};
            toggle_reg <= ~toggle_reg;
        end
    end

    // Read data is driven on falling edges during the data half of a read.
    always_ff @(negedge sclk) begin
        if (bitcnt_reg == 4'd8) begin
            rdata_hold_reg <= rdata;
        end else begin
            rdata_hold_reg <= {rdata_hold_reg[6:0], 1'b0};
        end
    end

    assign sdio_out = (bitcnt_reg == 4'd8) ? rdata[7] : rdata_hold_reg[7];
    assign sdio_oe  = bitcnt_reg[3] & ~addr_reg[7];

    // Toggle crossing into the system clock.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= toggle_reg;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // The strobe is registered with the word so both show the same request.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_reg   <= '0;
            req_valid <= 1'b0;
        end else begin
            req_valid <= sync2_reg ^ sync3_reg;
            if (sync2_reg ^ sync3_reg) begin
                req_reg <= hold_reg;
            end
        end
    end

endmodule : serial_link_port

// file: optical_motion_sensor_regs.sv
// Register bank of an optical motion sensor, reached over its serial port.
// Assumes motion samples come from the estimation datapath on clk.
`timescale 1ns/1ns
module optical_motion_sensor_regs #(
    parameter int SLEEP_CYCLES = sensor_regs_pkg::SLEEP_IDLE_CYCLES
) (
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    input  wire logic                           sclk,
    input  wire logic                           sdio_in,
    output logic                                sdio_out,
    output logic                                sdio_oe,
    input  wire sensor_regs_pkg::motion_sample_t sample,
    input  wire logic                           sample_valid,
    input  wire logic                           wake_request,
    input  wire logic                           high_resolution,
    output logic                                chip_reset,
    output logic                                power_down_select,
    output sensor_regs_pkg::op_state_t          op_state,
    output logic                                resolution_sel
);
    import sensor_regs_pkg::*;

    // ------------------------------------------------------------------
    // Serial access
    // ------------------------------------------------------------------
    reg_request_t req;
    logic         req_valid;
    logic [7:0]   rdata_reg;
    logic         wake_s1_reg;
    logic         wake_s2_reg;

    serial_link_port u_link (
        .sclk      (sclk),
        .clk       (clk),
        .rst_n     (rst_n),
        .sdio_in   (sdio_in),
        .sdio_out  (sdio_out),
        .sdio_oe   (sdio_oe),
        .rdata     (rdata_reg),
        .req_reg   (req),
        .req_valid (req_valid)
    );

    logic req_write;
    logic req_read;
    assign req_write = req_valid & req.write;
    assign req_read  = req_valid & ~req.write;

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic [7:0] ctrl_reg;
    logic       soft_reset_reg;
    logic       bank_rst_n;

    assign bank_rst_n = rst_n & ~soft_reset_reg;

    always_ff @(posedge clk) begin
        if (!bank_rst_n) begin
            ctrl_reg <= CTRL_RESET_VALUE;
        end else if (req_write && req.addr == ADDR_OPERATION_CONTROL) begin
            ctrl_reg <= req.wdata & CTRL_WRITABLE_MASK & 8'h7f;
        end
    end

    // Writing the reset bit pulses one cycle of bank reset; the link, rdata_reg and the wake synchronizer stay on rst_n.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            soft_reset_reg <= 1'b0;
        end else begin
            soft_reset_reg <= req_write && req.addr == ADDR_OPERATION_CONTROL
                              && req.wdata[CTRL_RESET_BIT];
        end
    end

    assign chip_reset        = soft_reset_reg;
    assign power_down_select = ctrl_reg[CTRL_POWER_DOWN_BIT];
    assign resolution_sel    = high_resolution;

    // ------------------------------------------------------------------
    // Sleep control
    // ------------------------------------------------------------------
    logic [$clog2(SLEEP_CYCLES+1)-1:0] idle_cnt_reg;
    op_state_t                         state_reg;
    logic                              moved;

    assign moved = sample_valid & sample.moved;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wake_s1_reg <= 1'b0;
            wake_s2_reg <= 1'b0;
        end else begin
            wake_s1_reg <= wake_request;
            wake_s2_reg <= wake_s1_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!bank_rst_n || moved || state_reg == OP_SLEEP) begin
            idle_cnt_reg <= '0;
        end else if (idle_cnt_reg != ($clog2(SLEEP_CYCLES+1))'(SLEEP_CYCLES)) begin
            idle_cnt_reg <= idle_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!bank_rst_n) begin
            state_reg <= OP_NORMAL;
        end else begin
            unique case (state_reg)
                OP_NORMAL: begin
                    if (!ctrl_reg[CTRL_SLEEP_BIT] && !ctrl_reg[CTRL_POWER_DOWN_BIT]
                        && idle_cnt_reg == ($clog2(SLEEP_CYCLES+1))'(SLEEP_CYCLES)
                        && !moved) begin
                        state_reg <= OP_SLEEP;
                    end
                end
                OP_SLEEP: begin
                    if (moved || wake_s2_reg) begin
                        state_reg <= OP_NORMAL;
                    end
                end
            endcase
        end
    end

    assign op_state = state_reg;

    // ------------------------------------------------------------------
    // Motion counters and quality
    // ------------------------------------------------------------------
    logic signed [7:0] y_count;
    logic signed [7:0] x_count;
    logic [7:0]        quality_reg;
    logic              clr_y;
    logic              clr_x;

    assign clr_y = req_read && req.addr == ADDR_VERTICAL_MOTION;
    assign clr_x = req_read && req.addr == ADDR_HORIZONTAL_MOTION;

    motion_accum #(.WIDTH(8)) u_acc_y (
        .clk       (clk),
        .rst_n     (bank_rst_n),
        .add_en    (sample_valid),
        .delta     (sample.dy),
        .clear     (clr_y),
        .count_reg (y_count)
    );

    motion_accum #(.WIDTH(8)) u_acc_x (
        .clk       (clk),
        .rst_n     (bank_rst_n),
        .add_en    (sample_valid),
        .delta     (sample.dx),
        .clear     (clr_x),
        .count_reg (x_count)
    );

    always_ff @(posedge clk) begin
        if (!bank_rst_n) begin
            quality_reg <= 8'h00;
        end else if (sample_valid) begin
            quality_reg <= sample.quality;
        end
    end

    // ------------------------------------------------------------------
    // Read data: taken from the frame's own address byte as soon as the
    // read request has crossed, so a clearing read reports the count.
    // ------------------------------------------------------------------
    function automatic logic [7:0] read_mux(input logic [6:0] a,
                                            input logic [7:0] c,
                                            input op_state_t  s,
                                            input logic [7:0] y,
                                            input logic [7:0] x,
                                            input logic [7:0] q);
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            ADDR_OPERATION_CONTROL: r = c;
            ADDR_PRODUCT_CODE:      r = {PRODUCT_CODE_VALUE, 4'h0, s == OP_NORMAL};
            ADDR_VERTICAL_MOTION:   r = y;
            ADDR_HORIZONTAL_MOTION: r = x;
            ADDR_FRAME_QUALITY:     r = q;
            ADDR_IDENTIFIER_UPPER:  r = IDENTIFIER_VALUE[11:4];
            ADDR_IDENTIFIER_LOWER:  r = {IDENTIFIER_VALUE[3:0], IDENTIFIER_LOW_PAD};
            default:                r = 8'h00;
        endcase
        return r;
    endfunction : read_mux

    // The word is taken in the cycle the read lands, ahead of the clear that
    // the same read causes, and holds while the link shifts it out. The link
    // half period must span about five system clocks for it to be ready.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else if (req_read) begin
            rdata_reg <= read_mux(req.addr, ctrl_reg, state_reg,
                                  y_count, x_count, quality_reg);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_soft_reset;
        @(posedge clk) disable iff (!rst_n)
        (req_write && req.addr == ADDR_OPERATION_CONTROL && req.wdata[7])
            |=> chip_reset ##1 (ctrl_reg == 8'h00);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

    property p_power_down;
        @(posedge clk) disable iff (!bank_rst_n)
        (req_write && req.addr == ADDR_OPERATION_CONTROL && !req.wdata[7])
            |=> (power_down_select == $past(req.wdata[6]));
    endproperty
    a_power_down: assert property (p_power_down) else $error("power down bit wrong");

    property p_reserved_zero;
        @(posedge clk) disable iff (!rst_n)
        (ctrl_reg & 8'hbe) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_sleep_only_idle;
        @(posedge clk) disable iff (!bank_rst_n)
        (state_reg == OP_NORMAL ##1 state_reg == OP_SLEEP)
            |-> $past(ctrl_reg[0]) == 1'b0;
    endproperty
    a_sleep_only_idle: assert property (p_sleep_only_idle) else $error("bad sleep");

    property p_wake;
        @(posedge clk) disable iff (!bank_rst_n)
        (state_reg == OP_SLEEP && moved) |=> state_reg == OP_NORMAL;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on motion");

    property p_clear_y;
        @(posedge clk) disable iff (!bank_rst_n)
        (clr_y && !sample_valid) |=> y_count == 8'sh00;
    endproperty
    a_clear_y: assert property (p_clear_y) else $error("Y not cleared");

    property p_clear_x;
        @(posedge clk) disable iff (!bank_rst_n)
        (clr_x && !sample_valid) |=> x_count == 8'sh00;
    endproperty
    a_clear_x: assert property (p_clear_x) else $error("X not cleared");

    property p_y_saturate;
        @(posedge clk) disable iff (!bank_rst_n)
        (sample_valid && !clr_y && y_count == 8'sh7f && !sample.dy[7])
            |=> y_count == 8'sh7f;
    endproperty
    a_y_saturate: assert property (p_y_saturate) else $error("Y wrapped");

    property p_identifier;
        @(posedge clk) disable iff (!rst_n)
        (req_read && req.addr == ADDR_IDENTIFIER_UPPER)
            |=> rdata_reg == IDENTIFIER_VALUE[11:4];
    endproperty
    a_identifier: assert property (p_identifier) else $error("id upper wrong");

    property p_chip_reset_pulse;
        @(posedge clk) disable iff (!rst_n)
        chip_reset |=> !chip_reset;
    endproperty
    a_chip_reset_pulse: assert property (p_chip_reset_pulse) else $error("reset too long");

    property p_wake_request;
        @(posedge clk) disable iff (!bank_rst_n)
        (state_reg == OP_SLEEP && wake_s2_reg) |=> state_reg == OP_NORMAL;
    endproperty
    a_wake_request: assert property (p_wake_request) else $error("no wake on request");

    property p_x_saturate;
        @(posedge clk) disable iff (!bank_rst_n)
        (sample_valid && !clr_x && x_count == 8'sh80 && sample.dx[7])
            |=> x_count == 8'sh80;
    endproperty
    a_x_saturate: assert property (p_x_saturate) else $error("X wrapped");

    property p_product_read;
        @(posedge clk) disable iff (!rst_n)
        (req_read && req.addr == ADDR_PRODUCT_CODE)
            |=> rdata_reg == {PRODUCT_CODE_VALUE, 4'h0, $past(state_reg) == OP_NORMAL};
    endproperty
    a_product_read: assert property (p_product_read) else $error("product word wrong");

endmodule : optical_motion_sensor_regs

// file: host_link_model.sv
// Host side model of the two-wire serial port of the motion sensor.
// Assumes frames are started one at a time by the testbench through frame.
`timescale 1ns/1ns
module host_link_model #(
    parameter int HALF_NS = 40,
    parameter int GAP_NS  = 200
) (
    output logic      sclk,
    output logic      sdio_in,
    input  wire logic sdio_out,
    input  wire logic sdio_oe
);
    logic host_bit = 1'b0;
    logic host_oe  = 1'b0;
    logic last_bit = 1'b0;

    initial begin
        sclk = 1'b0;
    end

    // --------------------------------------------------------------
    // Wire level
    // --------------------------------------------------------------
    // The line has no pull, so a released line shows the inverse of its last level.
    always_comb sdio_in = sdio_oe ? sdio_out : (host_oe ? host_bit : ~last_bit);

    always @(posedge sclk) begin
        last_bit <= sdio_in;
    end

    // --------------------------------------------------------------
    // Frame
    // --------------------------------------------------------------
    // The clock stands low outside frames; bits change while it is low.
    task automatic frame(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                         output logic [7:0] rdata);
        logic [15:0] word;
        word  = {wr, addr, wdata};
        rdata = 8'h00;
        host_oe = 1'b1;
        for (int i = 0; i < 16; i++) begin
            if (i == 8 && !wr) begin
                host_oe = 1'b0;
            end
            host_bit = word[15-i];
            #(HALF_NS);
            sclk = 1'b1;
            if (i >= 8) begin
                rdata[15-i] = sdio_in;
            end
            #(HALF_NS);
            sclk = 1'b0;
        end
        host_oe = 1'b0;
        #(GAP_NS);
    endtask : frame
endmodule : host_link_model

// file: testbench.sv
// Self-checking testbench of the motion sensor register bank.
// Assumes the host model for the serial port and the design package.
`timescale 1ns/1ns
module testbench;
    import sensor_regs_pkg::*;

    logic           clk             = 1'b0;
    logic           rst_n           = 1'b0;
    logic           sclk;
    logic           sdio_in;
    logic           sdio_out;
    logic           sdio_oe;
    motion_sample_t sample          = '0;
    logic           sample_valid    = 1'b0;
    logic           wake_request    = 1'b0;
    logic           high_resolution = 1'b0;
    logic           chip_reset;
    logic           power_down_select;
    op_state_t      op_state;
    logic           resolution_sel;
    int             fails       = 0;
    int             comparisons = 0;
    int             pulses      = 0;
    logic [7:0]     rd;

    initial begin
        forever #2 clk = ~clk;
    end

    optical_motion_sensor_regs #(.SLEEP_CYCLES(100)) DUT (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sample(sample),
        .sample_valid(sample_valid), .wake_request(wake_request),
        .high_resolution(high_resolution), .chip_reset(chip_reset),
        .power_down_select(power_down_select), .op_state(op_state),
        .resolution_sel(resolution_sel)
    );

    host_link_model host (
        .sclk(sclk), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe)
    );

    // Counts clock cycles with the reset pulse high, so width and count are seen together.
    always @(posedge clk) begin
        if (chip_reset === 1'b1) begin
            pulses <= pulses + 1;
        end
    end

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Read data belongs to the frame's own address byte.
    task automatic reg_read(input logic [6:0] addr, output logic [7:0] data);
        host.frame(1'b0, addr, 8'h00, data);
    endtask : reg_read

    task automatic reg_write(input logic [6:0] addr, input logic [7:0] data);
        logic [7:0] unused;
        host.frame(1'b1, addr, data, unused);
    endtask : reg_write

    task automatic push(input logic [7:0] dx, input logic [7:0] dy, input logic [7:0] q,
                        input logic moved);
        @(negedge clk);
        sample       = {dx, dy, q, moved};
        sample_valid = 1'b1;
        @(negedge clk);
        sample_valid = 1'b0;
    endtask : push

    task automatic wait_state(input op_state_t s, input int bound);
        int n;
        n = 0;
        while (op_state !== s && n < bound) begin
            @(negedge clk);
            n++;
        end
        check({7'h00, op_state}, {7'h00, s});
    endtask : wait_state

    task automatic results;
        $display("comparisons %0d, fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    // --------------------------------------------------------------
    // Sequence
    // --------------------------------------------------------------
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        #1;
        reg_read(ADDR_OPERATION_CONTROL, rd);
        check(rd, CTRL_RESET_VALUE);
        reg_read(ADDR_PRODUCT_CODE, rd);
        check({rd[7:5], 4'h0, rd[0]}, {PRODUCT_CODE_VALUE, 4'h0, 1'b0});
        push(8'h00, 8'h00, 8'h00, 1'b1);
        wait_state(OP_NORMAL, 10);
        repeat (80) @(negedge clk);
        check({7'h00, op_state}, 8'h01);
        wait_state(OP_SLEEP, 40);
        wake_request = 1'b1;
        wait_state(OP_NORMAL, 10);
        wake_request = 1'b0;
        reg_write(ADDR_OPERATION_CONTROL, 8'h7f);
        reg_read(ADDR_OPERATION_CONTROL, rd);
        check(rd, 8'h41);
        check({7'h00, power_down_select}, 8'h01);
        reg_write(ADDR_OPERATION_CONTROL, 8'h01);
        check({7'h00, power_down_select}, 8'h00);
        check(8'(pulses), 8'h00);
        push(8'h00, 8'h00, 8'h00, 1'b1);
        repeat (150) @(negedge clk);
        check({7'h00, op_state}, 8'h01);
        reg_read(ADDR_PRODUCT_CODE, rd);
        check({rd[7:5], 4'h0, rd[0]}, {PRODUCT_CODE_VALUE, 4'h0, 1'b1});
        reg_write(ADDR_IDENTIFIER_UPPER, 8'h00);
        reg_read(ADDR_IDENTIFIER_UPPER, rd);
        check(rd, IDENTIFIER_VALUE[11:4]);
        reg_read(ADDR_IDENTIFIER_LOWER, rd);
        check({rd[7:4], 4'h0}, {IDENTIFIER_VALUE[3:0], 4'h0});
        reg_read(7'h10, rd);
        check(rd, 8'h00);
        reg_read(ADDR_VERTICAL_MOTION, rd);
        reg_read(ADDR_HORIZONTAL_MOTION, rd);
        repeat (3) push(8'hfd, 8'h05, 8'hc8, 1'b1);
        reg_read(ADDR_VERTICAL_MOTION, rd);
        check(rd, 8'h0f);
        reg_read(ADDR_HORIZONTAL_MOTION, rd);
        check(rd, 8'hf7);
        reg_read(ADDR_VERTICAL_MOTION, rd);
        check(rd, 8'h00);
        reg_read(ADDR_HORIZONTAL_MOTION, rd);
        check(rd, 8'h00);
        reg_read(ADDR_FRAME_QUALITY, rd);
        check(rd, 8'hc8);
        repeat (3) push(8'h9c, 8'h64, 8'hff, 1'b1);
        reg_read(ADDR_VERTICAL_MOTION, rd);
        check(rd, 8'h7f);
        reg_read(ADDR_HORIZONTAL_MOTION, rd);
        check(rd, 8'h80);
        reg_read(ADDR_FRAME_QUALITY, rd);
        check(rd, 8'hff);
        high_resolution = 1'b1;
        @(negedge clk);
        check({7'h00, resolution_sel}, 8'h01);
        high_resolution = 1'b0;
        @(negedge clk);
        check({7'h00, resolution_sel}, 8'h00);
        reg_write(ADDR_OPERATION_CONTROL, 8'hc1);
        repeat (10) @(negedge clk);
        check(8'(pulses), 8'h01);
        check({7'h00, power_down_select}, 8'h00);
        reg_read(ADDR_OPERATION_CONTROL, rd);
        check(rd, CTRL_RESET_VALUE);
        results();
    end
endmodule : testbench
